// *** rtl/iibr_burst_readout.sv ***
// Purpose: Burst serial readout and parallel channel outputs
// Assumes: Chip select is high for at least three sys_clk periods
//   between frames and low at least three before the first spiClk rise
// Notes: Link logic runs on spiClk and is cleared while spiCsN is high
`timescale 1ns/1ns
module iibr_burst_readout
    import iibr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOe,
    input wire logic burstSelectPin,
    input wire logic outputEnable,
    input wire logic fieldSupply,
    input wire logic logicSupply,
    input wire logic [iibr_pkg::CHANNELS-1:0] fieldInput,
    input wire logic [iibr_pkg::CHANNELS-1:0] wireBreakInput,
    input wire logic overTemperatureFlag,
    input wire logic crcErrorFlag,
    input wire logic fieldPowerLossFlag,
    input wire logic logicUndervoltageFlag,
    output logic [iibr_pkg::CHANNELS-1:0] parallelChannelOutput,
    output logic [iibr_pkg::CHANNELS-1:0] parallelChannelOe,
    output logic frameSyncOutput,
    output logic burstMode
);
    import iibr_pkg::*;

    iibr_sys_t s;
    iibr_sys_t next_s;
    iibr_link_t l;
    iibr_link_t next_l;

    logic [SYNC_WIDTH-1:0] rawPins;
    logic [SYNC_WIDTH-1:0] syncPins;
    logic [7:0] inSync;
    logic [7:0] wbSync;
    logic burstSync;
    logic oeSync;
    logic fieldUp;
    logic logicUp;
    logic otSync;
    logic crcSync;
    logic pwrSync;
    logic uvloSync;
    logic csActive;
    logic frameEnd;
    logic faultRead;
    logic [7:0] faultNow;

    // Every pin in this bus crosses two flops before sys_clk use; the link uses spiSdi and spiCsN raw
    assign rawPins = {fieldInput, wireBreakInput, burstSelectPin,
        outputEnable, fieldSupply, logicSupply, overTemperatureFlag,
        crcErrorFlag, fieldPowerLossFlag, logicUndervoltageFlag,
        ~spiCsN};

    iibr_sync2 #(
        .W(SYNC_WIDTH)
    ) pinSync (
        .clk(sys_clk),
        .reset_n(reset_n),
        .d(rawPins),
        .q(syncPins)
    );

    assign inSync = syncPins[24:17];
    assign wbSync = syncPins[16:9];
    assign burstSync = syncPins[8];
    assign oeSync = syncPins[7];
    assign fieldUp = syncPins[6];
    assign logicUp = syncPins[5];
    assign otSync = syncPins[4];
    assign crcSync = syncPins[3];
    assign pwrSync = syncPins[2];
    assign uvloSync = syncPins[1];
    assign csActive = syncPins[0];

    always_comb begin
        next_s = s;
        frameEnd = s.csPrev && !csActive;
        faultRead = frameEnd && (s.regIndex == REG_FAULT);
        next_s.csPrev = csActive;

        // Strap is caught once the synchroniser has settled
        if (!s.strapTaken) begin
            if (s.strapCount == STRAP_SETTLE) begin
                next_s.strapTaken = 1'b1;
                next_s.burstMode = burstSync;
            end else begin
                next_s.strapCount = s.strapCount + 2'h1;
            end
        end

        // Register index steps at each frame end in burst mode only, for all chained parts
        if (frameEnd && s.burstMode) begin
            case (s.regIndex)
                REG_INPUT: next_s.regIndex = REG_WIRE;
                REG_WIRE: next_s.regIndex = REG_FAULT;
                default: next_s.regIndex = REG_INPUT;
            endcase
        end

        faultNow = 8'h00;
        faultNow[FLT_WB] = |wbSync;
        faultNow[FLT_OT] = otSync;
        faultNow[FLT_CRC] = crcSync;
        faultNow[FLT_PWR] = pwrSync | !fieldUp;
        faultNow[FLT_LOGIC_UNDERVOLTAGE_FLAG] = uvloSync;
        // Read clears only absent faults; a new fault always sets.
        // Held until the synchroniser has settled, so its reset
        // value is not taken for a field power loss.
        if (!s.strapTaken) begin
            next_s.faultLatch = s.faultLatch;
        end else if (faultRead) begin
            next_s.faultLatch = faultNow;
        end else begin
            next_s.faultLatch = s.faultLatch | faultNow;
        end

        // Word for the link is refreshed only between frames
        if (!csActive) begin
            case (next_s.regIndex)
                REG_INPUT: next_s.txWord = inSync;
                REG_WIRE: next_s.txWord = wbSync;
                default: next_s.txWord = next_s.faultLatch;
            endcase
        end

        next_s.frameSync = next_s.burstMode &&
            (next_s.regIndex == REG_INPUT);

        if (!logicUp) begin
            next_s.fieldEverUp = 1'b0;
            next_s.chanOe = 8'h00;
            next_s.chanOut = 8'h00;
        end else begin
            if (fieldUp) begin
                next_s.fieldEverUp = 1'b1;
            end
            if (!oeSync) begin
                next_s.chanOe = 8'h00;
            end else begin
                next_s.chanOe = 8'hff;
                if (fieldUp) begin
                    next_s.chanOut = inSync;
                end else if (!s.fieldEverUp) begin
                    next_s.chanOut = 8'h00;
                end else begin
                    next_s.chanOut = s.chanOut;
                end
            end
        end
        if (next_s.burstMode) begin
            next_s.chanOut[7] = next_s.frameSync;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{strapCount: 2'h0, strapTaken: 1'b0, burstMode: 1'b0,
                csPrev: 1'b0, regIndex: REG_INPUT, txWord: TX_RESET,
                faultLatch: FAULT_RESET, fieldEverUp: 1'b0,
                chanOut: 8'h00, chanOe: 8'h00, frameSync: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Link side: txWord is steady for the whole frame
    always_comb begin
        next_l.started = 1'b1;
        if (l.started) begin
            next_l.shiftReg = {l.shiftReg[6:0], spiSdi};
        end else begin
            next_l.shiftReg = {s.txWord[6:0], spiSdi};
        end
    end

    // Chip select high ends the frame even with spiClk stopped
    always_ff @(posedge spiClk or posedge spiCsN) begin
        if (spiCsN) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // First bit must be valid before the first rising edge
    assign spiSdo = l.started ? l.shiftReg[7] : s.txWord[7];
    assign spiSdoOe = !spiCsN;

    assign parallelChannelOutput = s.chanOut;
    assign parallelChannelOe = s.chanOe;
    assign frameSyncOutput = s.frameSync;
    assign burstMode = s.burstMode;

    sequence seq_poweredOn;
        logicUp && oeSync && fieldUp;
    endsequence

    sequence seq_fieldLost;
        logicUp && oeSync && s.fieldEverUp && !fieldUp;
    endsequence

    sequence seq_frameDone;
        s.burstMode && frameEnd;
    endsequence

    a_mode_strap_taken: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(s.strapTaken) |-> s.burstMode == $past(burstSync))
        else $error("burst mode not taken from strap");

    a_mode_stays_put: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s.strapTaken |=> $stable(s.burstMode))
        else $error("mode changed without reset");

    a_index_cycles: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        seq_frameDone |=>
            s.regIndex == (($past(s.regIndex) == REG_FAULT) ?
                REG_INPUT : iibr_reg_t'($past(s.regIndex) + 2'h1)))
        else $error("register index did not advance");

    a_index_first: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(s.strapTaken) |-> s.regIndex == REG_INPUT)
        else $error("first frame not input state");

    a_sync_input_state_register: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s.burstMode |-> parallelChannelOutput[7] ==
            (s.regIndex == REG_INPUT) && frameSyncOutput ==
            (s.regIndex == REG_INPUT))
        else $error("sync output wrong for register index");

    a_follow_input: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        seq_poweredOn ##1 seq_poweredOn |->
            parallelChannelOutput[6:0] == $past(inSync[6:0], 1) &&
            parallelChannelOe == 8'hff)
        else $error("output does not follow input");

    a_pulse_passes: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        seq_poweredOn ##1 (seq_poweredOn and $rose(inSync[0]))
            |-> ##[1:2] parallelChannelOutput[0])
        else $error("input pulse lost");

    a_tristate_oe: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        logicUp && !oeSync |=> parallelChannelOe == 8'h00)
        else $error("outputs driven with enable low");

    a_never_low: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        logicUp && oeSync && !fieldUp && !s.fieldEverUp |=>
            parallelChannelOutput[6:0] == 7'h00)
        else $error("unpowered field output not low");

    a_hold_lost: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        seq_fieldLost ##1 seq_fieldLost |->
            $stable(parallelChannelOutput[6:0]))
        else $error("output not held after field loss");

    a_fault_sticky: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s.faultLatch[FLT_OT] && !faultRead |=> s.faultLatch[FLT_OT])
        else $error("fault bit cleared without read");

    a_fault_clear: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        faultRead && !otSync |=> !s.faultLatch[FLT_OT])
        else $error("fault bit kept after read");

    a_shift_chain: assert property (
        @(posedge spiClk) disable iff (spiCsN)
        l.started |=> l.shiftReg[7:1] == $past(l.shiftReg[6:0]))
        else $error("chain shift broken");

    a_load_word: assert property (
        @(posedge spiClk) disable iff (spiCsN)
        !l.started |=> l.shiftReg[7:1] == $past(s.txWord[6:0]))
        else $error("frame not loaded with register word");

    a_logic_down: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !logicUp |=> parallelChannelOe == 8'h00 &&
            parallelChannelOutput[6:0] == 7'h00)
        else $error("outputs active without logic supply");

    a_logic_return: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !logicUp ##1 seq_poweredOn |=>
            parallelChannelOutput[6:0] == $past(inSync[6:0]))
        else $error("output missed input at logic power up");

    a_fault_wb: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s.strapTaken && (|wbSync) |=> s.faultLatch[FLT_WB])
        else $error("wire break not in fault byte");

    a_fault_crc: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s.strapTaken && crcSync |=> s.faultLatch[FLT_CRC])
        else $error("crc error not in fault byte");

    a_fault_pwr: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s.strapTaken && pwrSync |=> s.faultLatch[FLT_PWR])
        else $error("field power loss not in fault byte");

    a_sync_drops: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        seq_frameDone ##0 s.regIndex == REG_INPUT |=> !frameSyncOutput)
        else $error("sync output stayed high after input frame");

    a_sync_rises: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        seq_frameDone ##0 s.regIndex == REG_FAULT |=> frameSyncOutput)
        else $error("sync output missing before input frame");

    a_word_steady: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        csActive |=> $stable(s.txWord))
        else $error("frame word changed during frame");
endmodule // iibr_burst_readout

// *** rtl/iibr_pkg.sv ***
// Purpose: Shared constants and state types for the burst readout block
// Assumes: sys_clk at 100 MHz
// Notes: Fault register bit positions match the serial fault byte
package iibr_pkg;
    localparam int SYS_PERIOD_NS = 10;
    localparam int MIN_PULSE_NS = 667;
    localparam int MIN_PULSE_CYCLES = MIN_PULSE_NS / SYS_PERIOD_NS;
    localparam int CHANNELS = 8;
    localparam int SYNC_WIDTH = 25;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam int FLT_WB = 7;
    localparam int FLT_OT = 6;
    localparam int FLT_CRC = 4;
    localparam int FLT_PWR = 2;
    localparam int FLT_LOGIC_UNDERVOLTAGE_FLAG = 0;
    localparam logic [7:0] TX_RESET = 8'h00;
    localparam logic [7:0] FAULT_RESET = 8'h00;

    typedef enum logic [1:0] {
        REG_INPUT,
        REG_WIRE,
        REG_FAULT
    } iibr_reg_t;

    typedef struct packed {
        logic [1:0] strapCount;
        logic strapTaken;
        logic burstMode;
        logic csPrev;
        iibr_reg_t regIndex;
        logic [7:0] txWord;
        logic [7:0] faultLatch;
        logic fieldEverUp;
        logic [7:0] chanOut;
        logic [7:0] chanOe;
        logic frameSync;
    } iibr_sys_t;

    typedef struct packed {
        logic started;
        logic [7:0] shiftReg;
    } iibr_link_t;
endpackage

// *** rtl/iibr_sync2.sv ***
// Purpose: Two-stage synchroniser for a bus of independent levels
// Assumes: Each bit is a level; bits are not sampled as a word
// Notes: Stage one feeds stage two only
`timescale 1ns/1ns
module iibr_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule // iibr_sync2

// *** tb/iibr_burst_readout_tb.sv ***
// Purpose: Self-checking bench for the burst readout block
// Assumes: Single device; chain shown by feeding an upstream byte
// Notes: Parallel path tested in address mode so channel 8 is data
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin checks++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module iibr_burst_readout_tb;
    import iibr_pkg::*;
    typedef struct packed {
        logic ls;
        logic fs;
        logic oe;
        logic [7:0] din;
        logic [7:0] expOut;
        logic [7:0] expOe;
    } iibr_row_t;
    logic sys_clk, reset_n, spiClk, spiCsN, spiSdi, spiSdo, spiSdoOe;
    logic burstSelectPin, outputEnable, fieldSupply, logicSupply;
    logic [7:0] fieldInput, wireBreakInput, parallelChannelOutput;
    logic [7:0] parallelChannelOe;
    logic overTemperatureFlag, crcErrorFlag, fieldPowerLossFlag;
    logic logicUndervoltageFlag, frameSyncOutput, burstMode;
    int checks = 0;
    int num_errors = 0;
    int hi;
    iibr_row_t rows [8] = '{
        '{1'b1, 1'b0, 1'b1, 8'hff, 8'h00, 8'hff},
        '{1'b1, 1'b1, 1'b1, 8'ha5, 8'ha5, 8'hff},
        '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 8'hff},
        '{1'b1, 1'b1, 1'b0, 8'hff, 8'h00, 8'h00},
        '{1'b1, 1'b1, 1'b1, 8'h3c, 8'h3c, 8'hff},
        '{1'b1, 1'b0, 1'b1, 8'hff, 8'h3c, 8'hff},
        '{1'b0, 1'b1, 1'b1, 8'hff, 8'h00, 8'h00},
        '{1'b1, 1'b1, 1'b1, 8'h5a, 8'h5a, 8'hff}
    };

    iibr_burst_readout dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .spiClk(spiClk), .spiCsN(spiCsN), .spiSdi(spiSdi),
        .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
        .burstSelectPin(burstSelectPin), .outputEnable(outputEnable),
        .fieldSupply(fieldSupply), .logicSupply(logicSupply),
        .fieldInput(fieldInput), .wireBreakInput(wireBreakInput),
        .overTemperatureFlag(overTemperatureFlag),
        .crcErrorFlag(crcErrorFlag),
        .fieldPowerLossFlag(fieldPowerLossFlag),
        .logicUndervoltageFlag(logicUndervoltageFlag),
        .parallelChannelOutput(parallelChannelOutput),
        .parallelChannelOe(parallelChannelOe),
        .frameSyncOutput(frameSyncOutput), .burstMode(burstMode));
    iibr_spi_ctrl ctrl (.spiClk(spiClk), .spiCsN(spiCsN),
        .spiSdi(spiSdi), .spiSdo(spiSdo));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("Checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic b);
        @(negedge sys_clk);
        burstSelectPin = b;
        reset_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic faults(input logic [7:0] wb, input logic [3:0] f);
        @(negedge sys_clk);
        wireBreakInput = wb;
        {overTemperatureFlag, crcErrorFlag} = f[3:2];
        {fieldPowerLossFlag, logicUndervoltageFlag} = f[1:0];
        repeat (5) @(negedge sys_clk);
    endtask

    // Sync checked before the frame, then the shifted word
    task automatic bframe(input int n, input logic [15:0] sw,
        input logic [15:0] ew, input logic s);
        logic [15:0] got;
        `CHECK("sync", s, frameSyncOutput)
        `CHECK("ch8 sync", s, parallelChannelOutput[7])
        ctrl.frame(n, sw, got);
        `CHECK("frame", ew, got)
    endtask

    initial begin
        #200000;
        num_errors++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end

    // Output enable must follow chip select into the frame
    always @(negedge spiCsN) begin
        #1 `CHECK("sdo oe", 1'b1, spiSdoOe)
    end

    initial begin
        reset_n = 1'b0;
        burstSelectPin = 1'b0;
        outputEnable = 1'b1;
        fieldSupply = 1'b0;
        logicSupply = 1'b1;
        fieldInput = 8'h00;
        wireBreakInput = 8'h00;
        {overTemperatureFlag, crcErrorFlag} = 2'b00;
        {fieldPowerLossFlag, logicUndervoltageFlag} = 2'b00;
        do_reset(1'b0);
        `CHECK("idle sdo oe", 1'b0, spiSdoOe)
        foreach (rows[i]) begin
            {logicSupply, fieldSupply, outputEnable} = rows[i][26:24];
            fieldInput = rows[i].din;
            repeat (6) @(negedge sys_clk);
            `CHECK("chan oe", rows[i].expOe, parallelChannelOe)
            if (rows[i].expOe !== 8'h00)
                `CHECK("chan out", rows[i].expOut, parallelChannelOutput)
        end
        fieldInput = 8'h00;
        repeat (6) @(negedge sys_clk);
        hi = 0;
        for (int i = 0; i < 80; i++) begin
            @(negedge sys_clk);
            fieldInput[0] = (i < MIN_PULSE_CYCLES + 1);
            if (parallelChannelOutput[0] === 1'b1)
                hi++;
        end
        `CHECK("pulse cycles", MIN_PULSE_CYCLES + 1, hi)
        fieldInput = 8'ha5;
        do_reset(1'b1);
        `CHECK("mode", 1'b1, burstMode)
        faults(8'h04, 4'b1000);
        bframe(8, 16'h0000, 16'h00a5, 1'b1);
        bframe(8, 16'h0000, 16'h0004, 1'b0);
        bframe(8, 16'h0000, 16'h00c0, 1'b0);
        faults(8'h00, 4'b0111);
        bframe(16, 16'h3c00, 16'ha53c, 1'b1);
        bframe(8, 16'h0000, 16'h0000, 1'b0);
        bframe(8, 16'h0000, 16'h00d5, 1'b0);
        faults(8'h00, 4'b0000);
        bframe(8, 16'h0000, 16'h00a5, 1'b1);
        bframe(8, 16'h0000, 16'h0000, 1'b0);
        bframe(8, 16'h0000, 16'h0015, 1'b0);
        @(negedge sys_clk);
        burstSelectPin = 1'b0;
        repeat (10) @(negedge sys_clk);
        `CHECK("mode held", 1'b1, burstMode)
        fieldInput = 8'h25;
        do_reset(1'b0);
        `CHECK("mode after reset", 1'b0, burstMode)
        bframe(8, 16'h0000, 16'h0025, 1'b0);
        bframe(8, 16'h0000, 16'h0025, 1'b0);
        stop_test();
    end
endmodule // iibr_burst_readout_tb

// *** tb/iibr_spi_ctrl.sv ***
// Purpose: Serial controller model that reads burst frames
// Assumes: Mode 0, clock idle low, 12 ns link period
// Notes: Link clock runs only inside frames; data line toggles once as chip select rises
`timescale 1ns/1ns
module iibr_spi_ctrl (
    output logic spiClk,
    output logic spiCsN,
    output logic spiSdi,
    input wire logic spiSdo
);
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiSdi = 1'b1;
    end

    // One frame of n clocks; data in goes out MSB first from bit 15
    task automatic frame(input int n, input logic [15:0] sw,
        output logic [15:0] got);
        got = 16'h0000;
        spiCsN = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            spiSdi = sw[15 - i];
            #6 got = {got[14:0], spiSdo};
            spiClk = 1'b1;
            #6 spiClk = 1'b0;
        end
        #6 spiSdi = ~spiSdi;
        spiCsN = 1'b1;
        #80;
    endtask
endmodule // iibr_spi_ctrl
